// *** inc/ses_pkg.sv ***
// Constants and types shared by the servo stop sequencer
package ses_pkg;
	localparam int unsigned SES_CLK_HZ        = 10000000;
	localparam int unsigned SES_NAXIS         = 2;
	localparam int unsigned SES_CNT_W         = 24;
	localparam int unsigned SES_SPD_W         = 16;
	// Pull-up pulse length and retract torque length in microseconds
	localparam int unsigned SES_PULLUP_US     = 20;
	localparam int unsigned SES_PULLUP_CYC    = (SES_PULLUP_US * (SES_CLK_HZ / 1000000) > 0) ?
		SES_PULLUP_US * (SES_CLK_HZ / 1000000) : 1;
	localparam int unsigned SES_RETRACT_US    = 50;
	localparam int unsigned SES_RETRACT_CYC   = (SES_RETRACT_US * (SES_CLK_HZ / 1000000) > 0) ?
		SES_RETRACT_US * (SES_CLK_HZ / 1000000) : 1;
	// Earth-fault measurement time per axis
	localparam int unsigned SES_EFLT_US       = 10;
	localparam int unsigned SES_EFLT_CYC      = (SES_EFLT_US * (SES_CLK_HZ / 1000000) > 0) ?
		SES_EFLT_US * (SES_CLK_HZ / 1000000) : 1;
	// Full charge time, default 100 ms, a top-level parameter
	localparam int unsigned SES_CHARGE_MS     = 100;
	localparam int unsigned SES_CHARGE_CYC    = SES_CHARGE_MS * (SES_CLK_HZ / 1000);
	localparam logic [SES_CNT_W-1:0] SES_CNT_ZERO = 24'h000000;

	typedef enum logic [3:0] {
		SES_ST_OFF     = 4'b0000,
		SES_ST_EFLT    = 4'b0001,
		SES_ST_CHARGE  = 4'b0010,
		SES_ST_READY   = 4'b0011,
		SES_ST_RETRACT = 4'b0100,
		SES_ST_DECEL   = 4'b0101,
		SES_ST_PULLUP  = 4'b0110,
		SES_ST_BRAKE   = 4'b0111,
		SES_ST_STOPPED = 4'b1000
	} ses_state_t;
endpackage

// *** rtl/ses_axis_eflt.sv ***
// Per-axis earth-fault check, one axis after another
module ses_axis_eflt #(
	parameter int unsigned NAXIS = ses_pkg::SES_NAXIS
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_start,
	input  wire logic [NAXIS-1:0] i_leak_det,
	output logic      [NAXIS-1:0] o_meas_sel,
	output logic      [NAXIS-1:0] o_fault_axis,
	output logic                  o_done
);
	import ses_pkg::*;

	localparam int unsigned IDX_W = (NAXIS > 1) ? $clog2(NAXIS) : 1;

	logic             busy_r, busy_nxt;
	logic [IDX_W-1:0] idx_r, idx_nxt;
	logic [15:0]      tmr_r, tmr_nxt;
	logic [NAXIS-1:0] fault_r, fault_nxt;
	logic             done_r, done_nxt;

	// Walk axes; each gets its own window so a fault names its axis
	always_comb begin
		busy_nxt  = busy_r;
		idx_nxt   = idx_r;
		tmr_nxt   = tmr_r;
		fault_nxt = fault_r;
		done_nxt  = 1'b0;
		if (i_start && !busy_r) begin
			busy_nxt  = 1'b1;
			idx_nxt   = '0;
			tmr_nxt   = 16'(SES_EFLT_CYC - 1);
			fault_nxt = '0;
		end else if (busy_r) begin
			if (i_leak_det[idx_r])
				fault_nxt[idx_r] = 1'b1;
			if (tmr_r != 16'h0000) begin
				tmr_nxt = tmr_r - 16'h0001;
			end else if (32'(idx_r) == NAXIS - 1) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				idx_nxt = idx_r + IDX_W'(1);
				tmr_nxt = 16'(SES_EFLT_CYC - 1);
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_r  <= 1'b0;
			idx_r   <= '0;
			tmr_r   <= 16'h0000;
			fault_r <= '0;
			done_r  <= 1'b0;
		end else begin
			busy_r  <= busy_nxt;
			idx_r   <= idx_nxt;
			tmr_r   <= tmr_nxt;
			fault_r <= fault_nxt;
			done_r  <= done_nxt;
		end
	end

	// Only the axis under test is switched into the measuring circuit
	genvar g;
	generate
		for (g = 0; g < NAXIS; g++) begin : g_sel
			assign o_meas_sel[g] = busy_r && (32'(idx_r) == g);
		end
	endgenerate
	assign o_fault_axis = fault_r;
	assign o_done       = done_r;
endmodule

// *** rtl/ses_seq.sv ***
// Emergency-stop, brake, contactor and ready sequencer for a servo drive
// What this block does
// - On any stop source with decel control on, keep ready on while decelerating with the set time constant.
// - With decel control on, drop ready and apply dynamic brake only once the motor has stopped.
// - With drop prevention and decel control both on, delay ready-off by a set time after the brake command.
// - With pull-up and decel control both on, lift the vertical axis slightly before braking.
// - After stop release, check earth fault per axis before ready on.
// - On collision, produce retract torque, then decelerate to stop.
// - Drive monitors feed rate; exceeding safety speed raises stop and cuts power.
// - Contactor output follows stop, release, spindle stop and drop-prevention state.
// - Brake output follows stop, release, drop prevention and pull-up; all axes together.
// - External stop input opens the contactor even without a controller stop.
// - Flag is high while machine-end speed exceeds the set threshold.
// - Quick re-ready shortens charging according to remaining supply charge.
module ses_seq #(
	parameter int unsigned NAXIS      = ses_pkg::SES_NAXIS,
	parameter int unsigned SPD_W      = ses_pkg::SES_SPD_W,
	parameter int unsigned CNT_W      = ses_pkg::SES_CNT_W,
	parameter int unsigned CHARGE_CYC = ses_pkg::SES_CHARGE_CYC
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_nc_estop,
	input  wire logic             i_nc_fail,
	input  wire logic             i_servo_alarm,
	input  wire logic             i_ext_estop_n,
	input  wire logic             i_ready_req,
	input  wire logic             i_collision,
	input  wire logic             i_motor_stopped,
	input  wire logic             i_spindle_stop,
	input  wire logic             i_decel_en,
	input  wire logic             i_drop_prev_en,
	input  wire logic             i_pullup_en,
	input  wire logic [CNT_W-1:0] i_drop_delay,
	input  wire logic             i_safety_obs_en,
	input  wire logic [SPD_W-1:0] i_feed_speed,
	input  wire logic [SPD_W-1:0] i_safety_speed,
	input  wire logic [SPD_W-1:0] i_mach_speed,
	input  wire logic [SPD_W-1:0] i_spec_speed,
	input  wire logic [7:0]       i_charge_level,
	input  wire logic [NAXIS-1:0] i_leak_det,
	output logic                  o_ready,
	output logic                  o_decel_cmd,
	output logic                  o_dyn_brake,
	output logic [NAXIS-1:0]      o_brake_on,
	output logic                  o_pullup_cmd,
	output logic                  o_retract_cmd,
	output logic                  o_contactor_on,
	output logic                  o_overspeed_stop,
	output logic                  o_speed_over,
	output logic [NAXIS-1:0]      o_eflt_sel,
	output logic [NAXIS-1:0]      o_eflt_axis,
	output logic                  o_eflt_err,
	output ses_pkg::ses_state_t   o_state
);
	import ses_pkg::*;

	ses_state_t       st_r, st_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic             ovs_r, ovs_nxt;
	logic             spd_r, spd_nxt;
	logic             eflt_start;
	logic             eflt_done;
	logic [NAXIS-1:0] eflt_fault;
	logic             stop_src;
	logic             ext_stop;
	logic [CNT_W-1:0] charge_cyc;
	logic [CNT_W+8:0] charge_prod;
	// Output images, registered so brake and ready lines cannot glitch
	logic             rdy_r, rdy_nxt;
	logic             dec_r, dec_nxt;
	logic             dyn_r, dyn_nxt;
	logic             pul_r, pul_nxt;
	logic             ret_r, ret_nxt;
	logic             brk_r, brk_nxt;
	logic             con_r, con_nxt;

	// Stop sources merged; external input is active low (open contact stops)
	assign ext_stop = !i_ext_estop_n;
	assign stop_src = i_nc_estop || i_nc_fail || i_servo_alarm || ext_stop || ovs_r;

	// Remaining charge 0..255 scales the charging wait down linearly
	assign charge_prod = (CNT_W + 9)'(CHARGE_CYC) * (CNT_W + 9)'(8'hFF - i_charge_level);
	assign charge_cyc  = CNT_W'(charge_prod >> 8);

	// Safety speed and specified speed comparators, latched overspeed
	always_comb begin
		ovs_nxt = ovs_r;
		if (i_safety_obs_en && (i_feed_speed > i_safety_speed))
			ovs_nxt = 1'b1;
		else if (i_ready_req && !i_nc_estop && st_r == SES_ST_STOPPED)
			ovs_nxt = 1'b0;
		spd_nxt = i_mach_speed > i_spec_speed;
	end

	// Main sequence: run, stop decel, brake, ready-off, restart
	always_comb begin
		st_nxt     = st_r;
		cnt_nxt    = cnt_r;
		eflt_start = 1'b0;
		case (st_r)
			SES_ST_OFF: begin
				if (i_ready_req && !stop_src) begin
					st_nxt     = SES_ST_EFLT;
					eflt_start = 1'b1;
				end
			end
			SES_ST_EFLT: begin
				if (stop_src) begin
					st_nxt = SES_ST_STOPPED;
				end else if (eflt_done) begin
					if (eflt_fault != '0) begin
						st_nxt = SES_ST_STOPPED;
					end else begin
						st_nxt  = SES_ST_CHARGE;
						cnt_nxt = charge_cyc;
					end
				end
			end
			SES_ST_CHARGE: begin
				if (stop_src)
					st_nxt = SES_ST_STOPPED;
				else if (cnt_r == SES_CNT_ZERO)
					st_nxt = SES_ST_READY;
				else
					cnt_nxt = cnt_r - CNT_W'(1);
			end
			SES_ST_READY: begin
				if (stop_src) begin
					// Decel control off means the dynamic brake stops the motor
					st_nxt = i_decel_en ? SES_ST_DECEL : SES_ST_STOPPED;
				end else if (i_collision) begin
					st_nxt  = SES_ST_RETRACT;
					cnt_nxt = CNT_W'(SES_RETRACT_CYC - 1);
				end
			end
			SES_ST_RETRACT: begin
				if (cnt_r == SES_CNT_ZERO)
					st_nxt = SES_ST_DECEL;
				else
					cnt_nxt = cnt_r - CNT_W'(1);
			end
			SES_ST_DECEL: begin
				if (i_motor_stopped) begin
					if (i_pullup_en) begin
						st_nxt  = SES_ST_PULLUP;
						cnt_nxt = CNT_W'(SES_PULLUP_CYC - 1);
					end else if (i_drop_prev_en && i_decel_en) begin
						st_nxt  = SES_ST_BRAKE;
						cnt_nxt = SES_CNT_ZERO;
					end else begin
						st_nxt = SES_ST_STOPPED;
					end
				end
			end
			SES_ST_PULLUP: begin
				if (cnt_r == SES_CNT_ZERO) begin
					st_nxt  = (i_drop_prev_en && i_decel_en) ? SES_ST_BRAKE : SES_ST_STOPPED;
					cnt_nxt = SES_CNT_ZERO;
				end else begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end
			end
			SES_ST_BRAKE: begin
				// Brake is commanded; servo holds the axis until the count lands
				if (cnt_r + CNT_W'(1) >= i_drop_delay)
					st_nxt = SES_ST_STOPPED;
				else
					cnt_nxt = cnt_r + CNT_W'(1);
			end
			SES_ST_STOPPED: begin
				if (!stop_src && !i_ready_req)
					st_nxt = SES_ST_OFF;
			end
			default: begin
				st_nxt = SES_ST_OFF;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r  <= SES_ST_OFF;
			cnt_r <= SES_CNT_ZERO;
			ovs_r <= 1'b0;
			spd_r <= 1'b0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
			ovs_r <= ovs_nxt;
			spd_r <= spd_nxt;
		end
	end

	ses_axis_eflt #(
		.NAXIS (NAXIS)
	) u_eflt (
		.i_ref_clk    (i_ref_clk),
		.i_rst_n      (i_rst_n),
		.i_start      (eflt_start),
		.i_leak_det   (i_leak_det),
		.o_meas_sel   (o_eflt_sel),
		.o_fault_axis (eflt_fault),
		.o_done       (eflt_done)
	);

	// Output images follow the next state, so the registered copies match st_r
	always_comb begin
		rdy_nxt = 1'b0;
		dec_nxt = 1'b0;
		dyn_nxt = 1'b0;
		pul_nxt = 1'b0;
		ret_nxt = 1'b0;
		brk_nxt = 1'b0;
		// Sequence part of the contactor; overspeed drops it together with the latch
		con_nxt = !ovs_nxt && (st_nxt != SES_ST_OFF) && (st_nxt != SES_ST_STOPPED);
		// Ready stays on through every braking step until STOPPED
		case (st_nxt)
			SES_ST_OFF: begin
				dyn_nxt = 1'b1;
				brk_nxt = 1'b1;
			end
			SES_ST_EFLT: begin
				brk_nxt = 1'b1;
			end
			SES_ST_CHARGE: begin
				brk_nxt = 1'b1;
			end
			SES_ST_READY: begin
				rdy_nxt = 1'b1;
			end
			SES_ST_RETRACT: begin
				rdy_nxt = 1'b1;
				ret_nxt = 1'b1;
			end
			SES_ST_DECEL: begin
				rdy_nxt = 1'b1;
				dec_nxt = 1'b1;
			end
			SES_ST_PULLUP: begin
				rdy_nxt = 1'b1;
				pul_nxt = 1'b1;
			end
			SES_ST_BRAKE: begin
				// Servo still holds the axis while the brake closes
				rdy_nxt = 1'b1;
				brk_nxt = 1'b1;
			end
			SES_ST_STOPPED: begin
				dyn_nxt = 1'b1;
				brk_nxt = 1'b1;
			end
			default: begin
				dyn_nxt = 1'b1;
				brk_nxt = 1'b1;
			end
		endcase
	end

	// Reset values match the OFF state, so brakes hold from power-up on
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdy_r <= 1'b0;
			dec_r <= 1'b0;
			dyn_r <= 1'b1;
			pul_r <= 1'b0;
			ret_r <= 1'b0;
			brk_r <= 1'b1;
			con_r <= 1'b0;
		end else begin
			rdy_r <= rdy_nxt;
			dec_r <= dec_nxt;
			dyn_r <= dyn_nxt;
			pul_r <= pul_nxt;
			ret_r <= ret_nxt;
			brk_r <= brk_nxt;
			con_r <= con_nxt;
		end
	end

	// Direct stop inputs open the contactor without waiting for a clock edge
	assign o_contactor_on = !ext_stop && !i_spindle_stop && con_r;
	assign o_ready        = rdy_r;
	assign o_decel_cmd    = dec_r;
	assign o_dyn_brake    = dyn_r;
	assign o_pullup_cmd   = pul_r;
	assign o_retract_cmd  = ret_r;

	// One brake command fans out so every axis switches in the same cycle
	genvar g;
	generate
		for (g = 0; g < NAXIS; g++) begin : g_brk
			assign o_brake_on[g] = brk_r;
		end
	endgenerate

	assign o_overspeed_stop = ovs_r;
	assign o_speed_over     = spd_r;
	assign o_eflt_axis      = eflt_fault;
	assign o_eflt_err       = eflt_fault != '0;
	assign o_state          = st_r;
endmodule

// *** bench/ses_seq_monitor.sv ***
// Port-level assertions for the stop sequencer
module ses_seq_monitor
	import ses_pkg::*;
#(
	parameter int unsigned NAXIS = 2,
	parameter int unsigned SPD_W = 16
) (
	input wire logic             i_ref_clk,
	input wire logic             i_rst_n,
	input wire logic             i_ext_estop_n,
	input wire logic             i_spindle_stop,
	input wire logic             i_safety_obs_en,
	input wire logic [SPD_W-1:0] i_feed_speed,
	input wire logic [SPD_W-1:0] i_safety_speed,
	input wire logic [SPD_W-1:0] i_mach_speed,
	input wire logic [SPD_W-1:0] i_spec_speed,
	input wire logic             o_ready,
	input wire logic             o_decel_cmd,
	input wire logic             o_dyn_brake,
	input wire logic [NAXIS-1:0] o_brake_on,
	input wire logic             o_contactor_on,
	input wire logic             o_overspeed_stop,
	input wire logic             o_speed_over,
	input wire ses_state_t       o_state
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// Sequencing: ready held through decel, dropped only with dynamic brake
	property p_hold; o_decel_cmd |-> o_ready; endproperty
	a_hold: assert property (p_hold) else $error("ready low while decelerating");
	property p_fell; $fell(o_ready) |-> o_dyn_brake; endproperty
	a_fell: assert property (p_fell) else $error("ready fell without dynamic brake");
	property p_rose; $rose(o_ready) |-> $past(o_state) == SES_ST_CHARGE; endproperty
	a_rose: assert property (p_rose) else $error("ready rose outside charge");
	// Brakes and contactor
	property p_brk; o_brake_on == {NAXIS{o_brake_on[0]}}; endproperty
	a_brk: assert property (p_brk) else $error("axis brakes differ");
	property p_ext; !i_ext_estop_n |-> !o_contactor_on; endproperty
	a_ext: assert property (p_ext) else $error("contactor on during external stop");
	property p_spin; i_spindle_stop |-> !o_contactor_on; endproperty
	a_spin: assert property (p_spin) else $error("contactor on during spindle stop");
	// Speed observation, one register stage
	property p_spd; 1'h1 |=> o_speed_over == $past(i_mach_speed > i_spec_speed); endproperty
	a_spd: assert property (p_spd) else $error("speed flag wrong");
	property p_ovs;
		(o_ready && i_safety_obs_en && i_feed_speed > i_safety_speed) |=> o_overspeed_stop && !o_contactor_on;
	endproperty
	a_ovs: assert property (p_ovs) else $error("overspeed not stopped");
endmodule

// *** bench/ses_motor_model.sv ***
// Behavioural motor: comes to rest a set time after the decel command
module ses_motor_model #(
	parameter int unsigned STOP_CYC = 8
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	input  wire logic i_decel_cmd,
	input  wire logic i_ready,
	output logic      o_motor_stopped
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_r;
	// Spin-down time; held once reached so pull-up and brake see a still shaft
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			cnt_r <= 8'h00;
		else if (!i_ready)
			cnt_r <= 8'h00;
		else if (i_decel_cmd && cnt_r != STOP_CYC[7:0])
			cnt_r <= cnt_r + 8'h01;
	end
	assign o_motor_stopped = !i_ready || cnt_r == STOP_CYC[7:0];
endmodule

// *** bench/ses_seq_tb.sv ***
// Self-checking bench for the stop sequencer
module ses_seq_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ses_pkg::*;
	logic i_ref_clk = 1'h0, i_rst_n = 1'h0, i_nc_estop = 1'h0, i_nc_fail = 1'h0, i_servo_alarm = 1'h0;
	logic i_ext_estop_n = 1'h1, i_ready_req = 1'h0, i_collision = 1'h0, i_spindle_stop = 1'h0;
	logic i_decel_en = 1'h0, i_drop_prev_en = 1'h0, i_pullup_en = 1'h0, i_safety_obs_en = 1'h0;
	logic [23:0] i_drop_delay = 24'h000005;
	logic [15:0] i_feed_speed = 16'h0000, i_safety_speed = 16'h0080, i_mach_speed = 16'h0000;
	logic [15:0] i_spec_speed = 16'h0020;
	logic [7:0]  i_charge_level = 8'h00;
	logic [1:0]  i_leak_det = 2'h0, o_brake_on, o_eflt_sel, o_eflt_axis;
	logic        o_ready, o_decel_cmd, o_dyn_brake, o_pullup_cmd, o_retract_cmd, o_contactor_on;
	logic        o_overspeed_stop, o_speed_over, o_eflt_err, i_motor_stopped;
	ses_state_t  o_state;
	int          failures = 0, n_checks = 0, cyc, t0;
	typedef struct {logic [15:0] m; logic [15:0] s; logic e;} ses_row_t;
	ses_row_t rows [3] = '{'{16'h0010, 16'h0020, 1'h0}, '{16'h0020, 16'h0020, 1'h0}, '{16'h0021, 16'h0020, 1'h1}};
	// Short charge keeps the run brief
	ses_seq #(.CHARGE_CYC(50)) uut (.*);
	ses_motor_model u_mot (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_decel_cmd(o_decel_cmd),
		.i_ready(o_ready), .o_motor_stopped(i_motor_stopped));
	always #50 i_ref_clk = ~i_ref_clk;
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Bounded wait for a state; cyc holds the edges spent
	task automatic wait_st(input ses_state_t s);
		cyc = 0;
		while (o_state !== s) begin
			@(posedge i_ref_clk);
			#1;
			cyc++;
			if (cyc > 3000) begin
				$display("ERROR timeout waiting for state %h", s);
				failures++;
				tally_and_finish;
			end
		end
	endtask
	task automatic up(input logic [7:0] lv);
		@(posedge i_ref_clk);
		i_charge_level <= lv;
		i_ready_req <= 1'h1;
		wait_st(SES_ST_READY);
	endtask
	// Clears NC e-stop, servo alarm, external stop and ready request so the next bring-up starts from OFF
	task automatic rel;
		@(posedge i_ref_clk);
		i_nc_estop <= 1'h0;
		i_servo_alarm <= 1'h0;
		i_ext_estop_n <= 1'h1;
		i_ready_req <= 1'h0;
		wait_st(SES_ST_OFF);
	endtask
	initial begin
		// Flops only take their reset values at the first edge inside reset
		@(posedge i_ref_clk);
		#1;
		chk("rst_dyn", o_dyn_brake, 16'h0001);
		chk("rst_brk", o_brake_on, 16'h0003);
		#149 i_rst_n = 1'h1;
		foreach (rows[i]) begin
			@(posedge i_ref_clk);
			i_mach_speed <= rows[i].m;
			i_spec_speed <= rows[i].s;
			@(posedge i_ref_clk);
			#1 chk("spd", o_speed_over, rows[i].e);
		end
		up(8'h00);
		t0 = cyc;
		chk("cont", o_contactor_on, 16'h0001);
		@(posedge i_ref_clk);
		i_spindle_stop <= 1'h1;
		#1 chk("spin", o_contactor_on, 16'h0000);
		@(posedge i_ref_clk);
		i_spindle_stop <= 1'h0;
		i_nc_estop <= 1'h1;
		@(posedge i_ref_clk);
		#1 chk("nodec", o_ready, 16'h0000);
		rel;
		up(8'hFF);
		chk("quick", {15'h0000, cyc < t0}, 16'h0001);
		@(posedge i_ref_clk);
		i_ext_estop_n <= 1'h0;
		#1 chk("ext", o_contactor_on, 16'h0000);
		wait_st(SES_ST_STOPPED);
		rel;
		// Overspeed trip, then clear while still requesting ready
		up(8'hFF);
		@(posedge i_ref_clk);
		i_safety_obs_en <= 1'h1;
		i_feed_speed <= 16'h0100;
		@(posedge i_ref_clk);
		#1 chk("ovs", o_overspeed_stop, 16'h0001);
		wait_st(SES_ST_STOPPED);
		@(posedge i_ref_clk);
		i_feed_speed <= 16'h0000;
		@(posedge i_ref_clk);
		@(posedge i_ref_clk);
		#1 chk("ovs_clr", o_overspeed_stop, 16'h0000);
		rel;
		// Drop prevention always with decel enabled
		@(posedge i_ref_clk);
		i_decel_en <= 1'h1;
		i_drop_prev_en <= 1'h1;
		i_pullup_en <= 1'h1;
		up(8'hFF);
		@(posedge i_ref_clk);
		i_servo_alarm <= 1'h1;
		wait_st(SES_ST_DECEL);
		chk("dec_rdy", o_ready, 16'h0001);
		wait_st(SES_ST_PULLUP);
		chk("pull", o_pullup_cmd, 16'h0001);
		wait_st(SES_ST_BRAKE);
		chk("brk", o_brake_on, 16'h0003);
		wait_st(SES_ST_STOPPED);
		chk("delay", 16'(cyc), 16'h0005);
		chk("dyn", o_dyn_brake, 16'h0001);
		rel;
		// Collision retract then decel
		@(posedge i_ref_clk);
		i_pullup_en <= 1'h0;
		i_drop_prev_en <= 1'h0;
		up(8'hFF);
		@(posedge i_ref_clk);
		i_collision <= 1'h1;
		wait_st(SES_ST_RETRACT);
		chk("retr", o_retract_cmd, 16'h0001);
		@(posedge i_ref_clk);
		i_collision <= 1'h0;
		wait_st(SES_ST_DECEL);
		chk("coll_dec", o_decel_cmd, 16'h0001);
		wait_st(SES_ST_STOPPED);
		rel;
		// Earth fault on the second axis only
		@(posedge i_ref_clk);
		i_leak_det <= 2'h2;
		i_ready_req <= 1'h1;
		wait_st(SES_ST_EFLT);
		chk("esel0", o_eflt_sel, 16'h0001);
		// One measuring window per axis, then the next axis is switched in
		repeat (SES_EFLT_CYC) @(posedge i_ref_clk);
		#1 chk("esel1", o_eflt_sel, 16'h0002);
		wait_st(SES_ST_STOPPED);
		chk("eflt", o_eflt_axis, 16'h0002);
		chk("eerr", o_eflt_err, 16'h0001);
		tally_and_finish;
	end
endmodule
bind ses_seq ses_seq_monitor #(.NAXIS(NAXIS), .SPD_W(SPD_W)) u_mon (.*);
